// ---- rtl/rtccc_pkg.sv ----
package rtccc_pkg;
  localparam int RTCCC_IDX_CALENDAR_CONTROL_FIRST = 'h0;
  localparam int RTCCC_IDX_CALENDAR_CONTROL_SECOND = 'h2;
  localparam logic [11:0] RTCCC_ADDR_CALENDAR_CONTROL_FIRST = 12'(RTCCC_IDX_CALENDAR_CONTROL_FIRST * 4);
  localparam logic [11:0] RTCCC_ADDR_CALENDAR_CONTROL_SECOND = 12'(RTCCC_IDX_CALENDAR_CONTROL_SECOND * 4);
  localparam logic [11:0] RTCCC_ADDR_SYNC_BUSY_FLAGS = 12'h00C;
  localparam logic [11:0] RTCCC_ADDR_INTFLAG = 12'h010;
  localparam logic [11:0] RTCCC_ADDR_DEBUG = 12'h014;
  localparam logic [11:0] RTCCC_ADDR_COUNT = 12'h018;
  localparam logic [11:0] RTCCC_ADDR_TSTAMP = 12'h01C;
  localparam logic [11:0] RTCCC_ADDR_GP = 12'h020;
  localparam logic [11:0] RTCCC_ADDR_BACKUP = 12'h080;
  // Control word one fields.
  localparam int RTCCC_A_SRST = 0;
  localparam int RTCCC_A_EN = 1;
  localparam int RTCCC_A_MODE = 2;
  localparam int RTCCC_A_HOUR = 6;
  localparam int RTCCC_A_MCLR = 7;
  localparam int RTCCC_A_PRESC = 8;
  localparam int RTCCC_A_BKRST = 13;
  localparam int RTCCC_A_GPRST = 14;
  // Control word two fields.
  localparam int RTCCC_B_GP0 = 0;
  localparam int RTCCC_B_VOTE = 4;
  localparam int RTCCC_B_ASYNC = 5;
  localparam int RTCCC_B_OUTEN = 6;
  localparam int RTCCC_B_DMA = 7;
  localparam int RTCCC_B_DEBOUNCE_DIVIDER = 8;
  localparam int RTCCC_B_ACTIVE_LAYER_DIVIDER = 12;
  localparam logic [15:0] RTCCC_CALENDAR_CONTROL_SECOND_MASK = 16'h77F3;
  localparam logic [15:0] RTCCC_RESET16 = 16'h0000;
  localparam logic [3:0] RTCCC_PRESC_OFF = 4'h0;
  localparam logic [3:0] RTCCC_PRESC_MAX = 4'hB;
  localparam logic [3:0] RTCCC_PRESC_SHIFT_OFS = 4'h1;
  localparam logic [3:0] RTCCC_DIV_STEP = 4'h1;
  localparam int RTCCC_SYNC_TIME_NS = 30;
  localparam int RTCCC_CLK_NS = 10;
  localparam int RTCCC_SYNC_CYCLES =
    (RTCCC_SYNC_TIME_NS + RTCCC_CLK_NS - 1) / RTCCC_CLK_NS;
  typedef enum logic [1:0] {
    RTCCC_MODE_WIDE = 2'h0,
    RTCCC_MODE_HALF = 2'h1,
    RTCCC_MODE_CAL = 2'h2,
    RTCCC_MODE_RSVD = 2'h3
  } rtccc_mode_type;

  function automatic logic rtccc_tick_at(input logic [10:0] cnt,
                                         input logic [3:0] shift);
    logic [10:0] mask;
    mask = 11'((12'h001 << shift) - 12'h001);
    return (cnt & mask) == mask;
  endfunction
endpackage

// ---- rtl/rtccc_deb_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface rtccc_deb_if;
  logic tick;
  logic async_sel;
  logic vote_sel;
  logic raw;
  logic level;
  modport ctl (output tick, output async_sel, output vote_sel, output raw,
               input level);
  modport deb (input tick, input async_sel, input vote_sel, input raw,
               output level);
endinterface
`default_nettype wire

// ---- rtl/rtccc_divider.sv ----
`timescale 1ns/1ps
`default_nettype none
module rtccc_divider
  import rtccc_pkg::*;
(
  input wire logic pclk, // Clock.
  input wire logic presetn, // Async reset, active low.
  input wire logic run, // Counting allowed.
  input wire logic [3:0] shift, // Division is two to this power.
  output logic tick, // One-cycle pulse per divided period.
  output logic [10:0] count // Free-running stage count.
);
  logic [10:0] cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 11'h000;
    end else if (!run) begin
      cnt_reg <= 11'h000;
    end else begin
      cnt_reg <= cnt_reg + 11'h001;
    end
  end

  assign tick = run && rtccc_tick_at(cnt_reg, shift);
  assign count = cnt_reg;
endmodule
`default_nettype wire

// ---- rtl/rtccc_debounce.sv ----
`timescale 1ns/1ps
`default_nettype none
module rtccc_debounce (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Async reset, active low.
  input wire logic clear, // Soft reset of the sample history.
  rtccc_deb_if.deb bus // Debounce controls and result.
);
  logic [2:0] hist_reg;
  logic level_reg;
  logic sample;
  logic all_high, all_low, most_high;

  assign sample = bus.async_sel || bus.tick;
  assign all_high = &hist_reg;
  assign all_low = ~|hist_reg;
  assign most_high = (hist_reg[0] & hist_reg[1]) | (hist_reg[1] & hist_reg[2])
                   | (hist_reg[0] & hist_reg[2]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_reg <= 3'h0;
    end else if (clear) begin
      hist_reg <= 3'h0;
    end else if (sample) begin
      hist_reg <= {hist_reg[1:0], bus.raw};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg <= 1'b0;
    end else if (clear) begin
      level_reg <= 1'b0;
    end else if (bus.vote_sel) begin
      level_reg <= most_high;
    end else if (all_high || all_low) begin
      level_reg <= all_high;
    end
  end

  assign bus.level = level_reg;
endmodule
`default_nettype wire

// ---- rtl/rtccc_top.sv ----
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module rtccc_top
  import rtccc_pkg::*;
#(
  parameter int NGP = 2,
  parameter int NBK = 8
) (
  input wire logic pclk, // APB clock, also the source clock.
  input wire logic presetn, // Async reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic tamper_in, // Tamper input pin.
  output logic tamper_event, // Pulse on accepted tamper.
  output logic dma_req, // Timestamp DMA request pulse.
  output logic [7:0] periodic_event, // Periodic interval pulses.
  output logic active_out, // Active-layer clock output.
  output logic active_oe, // Active-layer output enable.
  output logic hour_format_select, // Hour format in force.
  output logic enabled // Peripheral enabled after sync.
);
  logic [15:0] calendar_control_first_reg, calendar_control_second_reg;
  logic debug_reg;
  logic enabled_reg, busy_en_reg, busy_srst_reg;
  logic [3:0] sync_cnt_reg;
  logic flag_reg;
  logic [31:0] count_reg, tstamp_reg;
  logic [31:0] gp_reg [NGP];
  logic [31:0] bk_reg [NBK];
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;
  logic tamper_ev_reg, dma_reg, out_reg, oe_reg, hour_reg;
  logic [7:0] per_reg;
  logic deb_prev_reg;

  logic setup, acc, wr, rd, sync_done, sw_clear, locked, tamper;
  logic cnt_tick, deb_tick, act_tick, match, ts_read;
  logic [3:0] presc_shift, deb_shift, act_shift;
  logic [10:0] pre_count;
  logic [31:0] count_next;
  rtccc_mode_type mode;
  rtccc_deb_if dbi ();

  function automatic logic hit(input logic [11:0] a);
    hit = (a == RTCCC_ADDR_CALENDAR_CONTROL_FIRST) || (a == RTCCC_ADDR_CALENDAR_CONTROL_SECOND) ||
          (a == RTCCC_ADDR_SYNC_BUSY_FLAGS) || (a == RTCCC_ADDR_INTFLAG) ||
          (a == RTCCC_ADDR_DEBUG) || (a == RTCCC_ADDR_COUNT) ||
          (a == RTCCC_ADDR_TSTAMP) ||
          ((a >= RTCCC_ADDR_GP) && (a < RTCCC_ADDR_GP + 12'(NGP * 4))) ||
          ((a >= RTCCC_ADDR_BACKUP) &&
           (a < RTCCC_ADDR_BACKUP + 12'(NBK * 4)));
  endfunction

  // APB handshake: one access cycle, answer registered at the setup edge.
  assign setup = psel && !penable && !pready_reg;
  assign acc = psel && penable && pready_reg && !pslverr_reg;
  assign wr = acc && pwrite && !busy_srst_reg;
  assign rd = acc && !pwrite;
  assign mode = rtccc_mode_type'(calendar_control_first_reg[RTCCC_A_MODE +: 2]);
  assign locked = calendar_control_first_reg[RTCCC_A_EN] || enabled_reg;
  assign sync_done = (sync_cnt_reg == 4'h0);
  assign sw_clear = busy_srst_reg && sync_done;
  assign ts_read = rd && (paddr == RTCCC_ADDR_TSTAMP);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !hit(paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_reg <= 32'h0000_0000;
      if (paddr == RTCCC_ADDR_CALENDAR_CONTROL_FIRST) begin
        prdata_reg[15:0] <= calendar_control_first_reg;
      end else if (paddr == RTCCC_ADDR_CALENDAR_CONTROL_SECOND) begin
        prdata_reg[15:0] <= calendar_control_second_reg;
      end else if (paddr == RTCCC_ADDR_SYNC_BUSY_FLAGS) begin
        prdata_reg[1:0] <= {busy_en_reg, busy_srst_reg};
      end else if (paddr == RTCCC_ADDR_INTFLAG) begin
        prdata_reg[0] <= flag_reg;
      end else if (paddr == RTCCC_ADDR_DEBUG) begin
        prdata_reg[0] <= debug_reg;
      end else if (paddr == RTCCC_ADDR_COUNT) begin
        prdata_reg <= count_reg;
      end else if (paddr == RTCCC_ADDR_TSTAMP) begin
        prdata_reg <= tstamp_reg;
      end else if (paddr >= RTCCC_ADDR_BACKUP) begin
        prdata_reg <= bk_reg[3'(paddr[11:2] - RTCCC_ADDR_BACKUP[11:2])];
      end else begin
        prdata_reg <= gp_reg[1'(paddr[11:2] - RTCCC_ADDR_GP[11:2])];
      end
    end else begin
      prdata_reg <= 32'h0000_0000;
    end
  end

  // Enable and soft reset share one synchronisation counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_cnt_reg <= 4'h0;
      busy_en_reg <= 1'b0;
      busy_srst_reg <= 1'b0;
      enabled_reg <= 1'b0;
    end else if (sw_clear) begin
      busy_en_reg <= 1'b0;
      busy_srst_reg <= 1'b0;
      enabled_reg <= 1'b0;
    end else if (wr && paddr == RTCCC_ADDR_CALENDAR_CONTROL_FIRST) begin
      sync_cnt_reg <= 4'(RTCCC_SYNC_CYCLES - 1);
      if (pwdata[RTCCC_A_SRST]) begin
        busy_srst_reg <= 1'b1;
      end else begin
        busy_en_reg <= 1'b1;
      end
    end else if (!sync_done) begin
      sync_cnt_reg <= sync_cnt_reg - 4'h1;
    end else if (busy_en_reg) begin
      busy_en_reg <= 1'b0;
      enabled_reg <= calendar_control_first_reg[RTCCC_A_EN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      calendar_control_first_reg <= RTCCC_RESET16;
    end else if (sw_clear) begin
      calendar_control_first_reg <= RTCCC_RESET16;
    end else if (wr && paddr == RTCCC_ADDR_CALENDAR_CONTROL_FIRST) begin
      if (pwdata[RTCCC_A_SRST]) begin
        calendar_control_first_reg[RTCCC_A_SRST] <= 1'b1;
      end else begin
        calendar_control_first_reg[RTCCC_A_EN] <= pwdata[RTCCC_A_EN];
        calendar_control_first_reg[RTCCC_A_MODE +: 2] <= pwdata[RTCCC_A_MODE +: 2];
        calendar_control_first_reg[RTCCC_A_PRESC +: 4] <= pwdata[RTCCC_A_PRESC +: 4];
        if (!locked) begin
          calendar_control_first_reg[RTCCC_A_HOUR] <= pwdata[RTCCC_A_HOUR];
          calendar_control_first_reg[RTCCC_A_MCLR] <= pwdata[RTCCC_A_MCLR];
          calendar_control_first_reg[RTCCC_A_BKRST] <= pwdata[RTCCC_A_BKRST];
          calendar_control_first_reg[RTCCC_A_GPRST] <= pwdata[RTCCC_A_GPRST];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      calendar_control_second_reg <= RTCCC_RESET16;
    end else if (sw_clear) begin
      calendar_control_second_reg <= RTCCC_RESET16;
    end else if (wr && paddr == RTCCC_ADDR_CALENDAR_CONTROL_SECOND && !locked) begin
      calendar_control_second_reg <= pwdata[15:0] & RTCCC_CALENDAR_CONTROL_SECOND_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_reg <= 1'b0;
    end else if (wr && paddr == RTCCC_ADDR_DEBUG) begin
      debug_reg <= pwdata[0];
    end
  end

  // Clock dividers for count, debounce and active-layer clocks.
  always_comb begin
    if (calendar_control_first_reg[RTCCC_A_PRESC +: 4] > RTCCC_PRESC_MAX) begin
      presc_shift = RTCCC_PRESC_MAX - RTCCC_PRESC_SHIFT_OFS;
    end else if (calendar_control_first_reg[RTCCC_A_PRESC +: 4] == RTCCC_PRESC_OFF) begin
      presc_shift = 4'h0;
    end else begin
      presc_shift = calendar_control_first_reg[RTCCC_A_PRESC +: 4] - RTCCC_PRESC_SHIFT_OFS;
    end
  end
  assign deb_shift = {1'b0, calendar_control_second_reg[RTCCC_B_DEBOUNCE_DIVIDER +: 3]}
                     + RTCCC_DIV_STEP;
  assign act_shift = {1'b0, calendar_control_second_reg[RTCCC_B_ACTIVE_LAYER_DIVIDER +: 3]};

  rtccc_divider u_cnt_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(enabled_reg),
    .shift(presc_shift),
    .tick(cnt_tick),
    .count(pre_count)
  );
  rtccc_divider u_deb_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(1'b1),
    .shift(deb_shift),
    .tick(deb_tick),
    .count()
  );
  rtccc_divider u_act_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(1'b1),
    .shift(act_shift),
    .tick(act_tick),
    .count()
  );

  // Periodic interval n fires when the prescaler stage n+1 rolls over.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_reg <= 8'h00;
    end else begin
      for (int n = 0; n < 8; n++) begin
        per_reg[n] <= enabled_reg && !sw_clear &&
          calendar_control_first_reg[RTCCC_A_PRESC +: 4] != RTCCC_PRESC_OFF &&
          rtccc_tick_at(pre_count, 4'(n + 1));
      end
    end
  end

  assign match = !calendar_control_second_reg[RTCCC_B_GP0] && (count_reg == gp_reg[0]);
  always_comb begin
    count_next = count_reg + 32'h0000_0001;
    if (mode == RTCCC_MODE_HALF) begin
      count_next[31:16] = 16'h0000;
    end
    if (match && calendar_control_first_reg[RTCCC_A_MCLR] &&
        (mode == RTCCC_MODE_WIDE || mode == RTCCC_MODE_CAL)) begin
      count_next = 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 32'h0000_0000;
    end else if (sw_clear) begin
      count_reg <= 32'h0000_0000;
    end else if (wr && paddr == RTCCC_ADDR_COUNT) begin
      count_reg <= pwdata;
    end else if (cnt_tick && mode != RTCCC_MODE_RSVD) begin
      count_reg <= count_next;
    end
  end

  // Tamper input path.
  assign dbi.tick = deb_tick;
  assign dbi.async_sel = calendar_control_second_reg[RTCCC_B_ASYNC];
  assign dbi.vote_sel = calendar_control_second_reg[RTCCC_B_VOTE];
  assign dbi.raw = tamper_in;
  rtccc_debounce u_deb (
    .pclk(pclk),
    .presetn(presetn),
    .clear(sw_clear),
    .bus(dbi)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deb_prev_reg <= 1'b0;
    end else begin
      deb_prev_reg <= dbi.level;
    end
  end
  assign tamper = enabled_reg && dbi.level && !deb_prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tstamp_reg <= 32'h0000_0000;
      flag_reg <= 1'b0;
    end else if (sw_clear) begin
      tstamp_reg <= 32'h0000_0000;
      flag_reg <= 1'b0;
    end else if (tamper) begin
      tstamp_reg <= count_reg;
      flag_reg <= 1'b1;
    end else if (ts_read && calendar_control_second_reg[RTCCC_B_DMA]) begin
      flag_reg <= 1'b0;
    end else if (wr && paddr == RTCCC_ADDR_INTFLAG && pwdata[0]) begin
      flag_reg <= 1'b0;
    end
  end

  // General-purpose words; word zero doubles as the compare value.
  generate
    for (genvar i = 0; i < NGP; i++) begin : g_gp
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          gp_reg[i] <= 32'h0000_0000;
        end else if (sw_clear) begin
          gp_reg[i] <= 32'h0000_0000;
        end else if (tamper && calendar_control_first_reg[RTCCC_A_GPRST] &&
                     calendar_control_second_reg[RTCCC_B_GP0 + i]) begin
          gp_reg[i] <= 32'h0000_0000;
        end else if (wr && paddr == RTCCC_ADDR_GP + 12'(i * 4)) begin
          gp_reg[i] <= pwdata;
        end
      end
    end
    for (genvar k = 0; k < NBK; k++) begin : g_bk
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          bk_reg[k] <= 32'h0000_0000;
        end else if (sw_clear) begin
          bk_reg[k] <= 32'h0000_0000;
        end else if (tamper && calendar_control_first_reg[RTCCC_A_BKRST]) begin
          bk_reg[k] <= 32'h0000_0000;
        end else if (wr && paddr == RTCCC_ADDR_BACKUP + 12'(k * 4)) begin
          bk_reg[k] <= pwdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tamper_ev_reg <= 1'b0;
      dma_reg <= 1'b0;
    end else begin
      tamper_ev_reg <= tamper;
      dma_reg <= tamper && calendar_control_second_reg[RTCCC_B_DMA];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (!calendar_control_second_reg[RTCCC_B_OUTEN] || !enabled_reg) begin
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= 1'b1;
      if (act_tick) begin
        out_reg <= !out_reg;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hour_reg <= 1'b0;
    end else begin
      hour_reg <= calendar_control_first_reg[RTCCC_A_HOUR] && mode == RTCCC_MODE_CAL;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign tamper_event = tamper_ev_reg;
  assign dma_req = dma_reg;
  assign periodic_event = per_reg;
  assign active_out = out_reg;
  assign active_oe = oe_reg;
  assign hour_format_select = hour_reg;
  assign enabled = enabled_reg;
endmodule
`default_nettype wire

// ---- bench/rtccc_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module rtccc_assertions
  import rtccc_pkg::*;
#(
  parameter int NGP = 2,
  parameter int NBK = 8
) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic pwrite, // Direction.
  input wire logic [11:0] paddr, // Address.
  input wire logic [31:0] pwdata, // Write data.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic tamper_event, // Tamper pulse.
  input wire logic dma_req, // DMA pulse.
  input wire logic [7:0] periodic_event, // Periodic pulses.
  input wire logic active_out, // Divided output.
  input wire logic active_oe, // Output enable.
  input wire logic hour_format_select, // Hour format.
  input wire logic enabled // Enabled after sync.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_en;
  assign wr_en = psel && penable && pready && pwrite && !enabled &&
                 paddr == RTCCC_ADDR_CALENDAR_CONTROL_FIRST && pwdata[1:0] == 2'b10;
  AST_SETUP_ANSWER: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held");
  AST_ERR_QUAL: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_EN_SYNC: assert property (wr_en |=> !enabled [*2] ##[1:3] enabled)
    else $error("enable not synchronised in time");
  AST_HOUR_LOCK: assert property (enabled && $past(enabled) |->
    $stable(hour_format_select)) else $error("hour format changed");
  AST_OE_GATE: assert property (active_oe |->
    enabled || $past(enabled)) else $error("output enabled while disabled");
  AST_OUT_IDLE: assert property (!enabled && !$past(enabled) &&
    !$past(enabled, 2) |-> !active_out) else $error("output toggles");
  AST_DMA_PAIR: assert property (dma_req |-> tamper_event)
    else $error("dma without tamper");
  AST_PER_GATE: assert property (|periodic_event |->
    enabled || $past(enabled)) else $error("periodic while disabled");
  AST_TAMPER_GATE: assert property (tamper_event |->
    enabled || $past(enabled)) else $error("tamper while disabled");
endmodule
bind rtccc_top rtccc_assertions #(.NGP(NGP), .NBK(NBK)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .tamper_event(tamper_event), .dma_req(dma_req),
  .periodic_event(periodic_event), .active_out(active_out),
  .active_oe(active_oe), .hour_format_select(hour_format_select),
  .enabled(enabled));
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rtccc_pkg::*;
  localparam logic [11:0] ACA = RTCCC_ADDR_CALENDAR_CONTROL_FIRST;
  localparam logic [11:0] ACB = RTCCC_ADDR_CALENDAR_CONTROL_SECOND;
  localparam logic [11:0] ASB = RTCCC_ADDR_SYNC_BUSY_FLAGS;
  localparam logic [11:0] AIF = RTCCC_ADDR_INTFLAG;
  localparam int NBK = 8;
  logic pclk, presetn, psel, penable, pwrite, tamper_in, act_q, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, g0, cbv, cnt0;
  logic pready, pslverr, tamper_event, dma_req, active_out, active_oe;
  logic hour_format_select, enabled;
  logic [7:0] periodic_event;
  logic [31:0] bk_val [NBK];
  int err_count, n_tests, n_tev, n_per, n_act, n_dma, i, k, p, a, t0, t1;
  rtccc_top #(.NGP(2), .NBK(NBK)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tamper_in(tamper_in),
    .tamper_event(tamper_event), .dma_req(dma_req),
    .periodic_event(periodic_event), .active_out(active_out),
    .active_oe(active_oe), .hour_format_select(hour_format_select),
    .enabled(enabled));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    act_q <= active_out;
    if (tamper_event === 1'b1) n_tev <= n_tev + 1;
    if (dma_req === 1'b1) n_dma <= n_dma + 1;
    if (periodic_event[0] === 1'b1) n_per <= n_per + 1;
    if (active_out === 1'b1 && act_q === 1'b0) n_act <= n_act + 1;
  end
  function automatic int exp_per(input int code);
    // Interval 0 pulses on every second stage cycle for any nonzero code; code 0 gives none.
    return (code == 0) ? 0 : 128;
  endfunction
  function automatic int exp_cnt(input int code);
    // The two count reads take their setup 259 cycles apart.
    return (code <= 1) ? 259 : 259 >> (code - 1);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic near(input int got, input int exp);
    check(32'(got >= exp - 1 && got <= exp + 1), 32'h1);
  endtask
  task automatic apb(input logic wr, input logic [11:0] ad,
                     input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #500000;
    err_count++;
    give_verdict;
  end
  initial begin
    {presetn, psel, penable, pwrite, tamper_in, act_q} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {err_count, n_tests, n_tev, n_per, n_act, n_dma} = 0;
    void'($urandom(53554));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ACA, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, ACB, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, ASB, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'hFFC, 32'h0);
    check(32'(perr), 32'h1);
    apb(1'b1, RTCCC_ADDR_DEBUG, 32'h1);
    cbv = $urandom;
    apb(1'b1, ACB, cbv);
    apb(1'b0, ACB, 32'h0);
    check(rd, cbv & 32'(RTCCC_CALENDAR_CONTROL_SECOND_MASK));
    for (i = 0; i < 2; i++) begin
      apb(1'b1, ACA, 32'h0000_6BCF);
      apb(1'b0, ACA, 32'h0);
      check(rd & 32'h1, 32'h1);
      repeat (8) @(posedge pclk);
      apb(1'b0, ACA, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, RTCCC_ADDR_DEBUG, 32'h0);
      check(rd, 32'h1);
      check(32'(enabled), 32'h0);
      check(32'(active_oe), 32'h0);
      for (k = 0; k < 4; k++) begin
        apb(1'b1, ACA, 32'(32'h40 | (k << 2)));
        repeat (2) @(posedge pclk);
        check(32'(hour_format_select), 32'(k == 2));
      end
      for (k = 0; k < NBK; k++) begin
        bk_val[k] = $urandom;
        apb(1'b1, RTCCC_ADDR_BACKUP + 12'(4 * k), bk_val[k]);
      end
      g0 = $urandom;
      apb(1'b1, RTCCC_ADDR_GP, g0);
      apb(1'b1, RTCCC_ADDR_GP + 12'h004, $urandom | 32'h1);
      p = (i == 0) ? 0 : 1 + $urandom % 4;
      a = $urandom % 4;
      cbv = 32'((a << 12) | (i << 7) | 32'h42 | (i << 5) | (i << 4));
      apb(1'b1, ACB, cbv);
      apb(1'b1, ACA, 32'(32'h40CA | (i << 13) | (p << 8)));
      apb(1'b0, ASB, 32'h0);
      check(rd & 32'h2, 32'h2);
      apb(1'b0, ACA, 32'h0);
      check(rd & 32'h2, 32'h2);
      k = 0;
      while (enabled !== 1'b1 && k < 20) begin
        @(posedge pclk);
        k++;
      end
      apb(1'b0, ASB, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, RTCCC_ADDR_COUNT, 32'h0);
      cnt0 = rd;
      t0 = n_per;
      t1 = n_act;
      repeat (256) @(posedge pclk);
      near(n_per - t0, exp_per(p));
      near(n_act - t1, 256 >> (a + 1));
      apb(1'b0, RTCCC_ADDR_COUNT, 32'h0);
      near(rd - cnt0, exp_cnt(p));
      check(32'(active_oe), 32'h1);
      apb(1'b1, ACA, 32'(32'h000A | (p << 8)));
      apb(1'b1, ACB, 32'h0);
      apb(1'b0, ACA, 32'h0);
      check(rd & 32'h60C0, 32'(32'h40C0 | (i << 13)));
      apb(1'b0, ACB, 32'h0);
      check(rd, cbv);
      t0 = n_tev;
      for (k = 0; k < 4; k++) begin
        @(posedge pclk);
        tamper_in <= ~k[0];
      end
      repeat (20) @(posedge pclk);
      check(32'(n_tev - t0), 32'(i));
      t0 = n_tev;
      tamper_in <= 1'b1;
      repeat (20) @(posedge pclk);
      tamper_in <= 1'b0;
      repeat (20) @(posedge pclk);
      check(32'(n_tev - t0), 32'h1);
      t0 = n_tev;
      tamper_in <= 1'b1;
      repeat (3) @(posedge pclk);
      tamper_in <= 1'b0;
      repeat (20) @(posedge pclk);
      check(32'(n_tev - t0), 32'(i));
      check(32'(n_dma), 32'(3 * i));
      apb(1'b0, AIF, 32'h0);
      check(rd & 32'h1, 32'h1);
      apb(1'b0, RTCCC_ADDR_TSTAMP, 32'h0);
      apb(1'b0, AIF, 32'h0);
      check(rd & 32'h1, 32'(1 - i));
      for (k = 0; k < NBK; k++) begin
        apb(1'b0, RTCCC_ADDR_BACKUP + 12'(4 * k), 32'h0);
        check(rd, (i == 1) ? 32'h0 : bk_val[k]);
      end
      apb(1'b0, RTCCC_ADDR_GP + 12'h004, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, RTCCC_ADDR_GP, 32'h0);
      check(rd, g0);
    end
    give_verdict;
  end
endmodule
`default_nettype wire
